// ### bench/usbfe_control_tb_top.sv
// Purpose: Self-checking bench for the USB interface front-end control block.
// Assumes: Expected values come from the register map, never from the design.
// Notes: Drivers queue expectations; one monitor pops and compares them.
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module usbfe_control_tb_top;
    import usbfe_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic obsReq = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic [1:0] lineCmd = LS_J;
    logic [5:0] otgCmd = 6'h00;
    logic [2:0] serCmd = 3'h0;
    logic actCmd = 1'b0;
    logic errCmd = 1'b0;
    logic [1:0] lineStatePin;
    logic [5:0] otgStatusPin;
    logic [2:0] rxSerialPin;
    logic rxActivePin, rxErrorPin;
    logic pktStart = 1'b0, tokenValid = 1'b0, pidValid = 1'b0;
    logic crc16Fail = 1'b0, sofValid = 1'b0, autoResume = 1'b0;
    logic [6:0] tokenAddr = 7'h00;
    logic [3:0] tokenEp = 4'h0, pidValue = 4'h0;
    logic [10:0] sofValue = 11'h000;
    logic [2:0] opMode, transceiverConfigPins;
    logic termSelect, xcvrSelect, txSe0, txData, txEnable_n, fullLowSpeedSerial;
    logic widePortPulldownDisable, suspendAutoResume;
    logic flagPortA, flagPortB, flagPortC, flagPortD;
    logic [7:0] otgControl;
    logic [3:0] filteredLineState;
    logic [4:0] rxEndpoint;
    logic [33:0] expQ[$];
    logic [33:0] ent;
    logic [31:0] r;
    int err_count = 0;
    int n_tests = 0;
    logic [7:0] rAddr[12] = '{ADDR_FUNC, ADDR_OTGCTL, ADDR_SERIAL, ADDR_STICKY, ADDR_MASKS,
        ADDR_SOF, ADDR_PID, ADDR_EP, ADDR_EPMARK, ADDR_OTGMASK, ADDR_POWER, ADDR_PHYCTL};
    logic [31:0] rMask[12] = '{32'h1f, 32'hdf, 32'h0f, 32'h7f, 32'hffffffff, 32'h7ff,
        32'h0, 32'h0, 32'hffff, 32'hffffffff, 32'h1ff, 32'h40ff0};
    wire [21:0] ctlVec = {otgControl, transceiverConfigPins, widePortPulldownDisable,
        suspendAutoResume, opMode, termSelect, xcvrSelect, txSe0, txData, txEnable_n,
        fullLowSpeedSerial};
    wire [12:0] portVec = {flagPortD, flagPortC, flagPortB, flagPortA, rxEndpoint,
        filteredLineState};

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    usbfe_xcvr_model xcvr (.clk(clk), .lineCmd(lineCmd), .otgCmd(otgCmd), .serCmd(serCmd),
        .actCmd(actCmd), .errCmd(errCmd), .lineStatePin(lineStatePin),
        .otgStatusPin(otgStatusPin), .rxSerialPin(rxSerialPin), .rxActivePin(rxActivePin),
        .rxErrorPin(rxErrorPin));

    usbfe_control #(.FILT_W(16)) dut (.clk(clk), .rst(rst), .clkEn(clkEn),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .lineStatePin(lineStatePin), .otgStatusPin(otgStatusPin),
        .rxSerialPin(rxSerialPin), .rxActivePin(rxActivePin), .rxErrorPin(rxErrorPin),
        .pktStart(pktStart), .tokenValid(tokenValid), .tokenAddr(tokenAddr),
        .tokenEp(tokenEp), .pidValid(pidValid), .pidValue(pidValue), .crc16Fail(crc16Fail),
        .sofValid(sofValid), .sofValue(sofValue), .autoResume(autoResume), .opMode(opMode),
        .termSelect(termSelect), .xcvrSelect(xcvrSelect), .otgControl(otgControl),
        .txSe0(txSe0), .txData(txData), .txEnable_n(txEnable_n),
        .fullLowSpeedSerial(fullLowSpeedSerial), .transceiverConfigPins(transceiverConfigPins),
        .widePortPulldownDisable(widePortPulldownDisable),
        .suspendAutoResume(suspendAutoResume), .filteredLineState(filteredLineState),
        .flagPortA(flagPortA), .flagPortB(flagPortB), .flagPortC(flagPortC),
        .flagPortD(flagPortD), .rxEndpoint(rxEndpoint));

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: values are read before the edge's own updates land, so no race.
    always @(posedge clk) begin
        if (regRead || obsReq) begin
            ent = expQ.pop_front();
            case (ent[33:32])
                2'h0: `CHK(regRdata, ent[31:0])
                2'h1: `CHK(ctlVec, ent[21:0])
                default: `CHK(portVec, ent[12:0])
            endcase
        end
    end

    // Full-word write; the strobe stands across exactly one rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask

    // Full-word read; the answer is due in the same cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        expQ.push_back({2'h0, e});
        @(negedge clk);
        regRead = 1'b0;
    endtask

    // Snapshot of a group of output pins.
    task automatic ob(input logic [1:0] k, input logic [31:0] e);
        @(negedge clk);
        obsReq = 1'b1;
        expQ.push_back({k, e});
        @(negedge clk);
        obsReq = 1'b0;
    endtask

    // One-cycle decoder pulses: {resume, sof, crc, pid, token, start}.
    task automatic ev(input logic [5:0] p);
        @(negedge clk);
        {autoResume, sofValid, crc16Fail, pidValid, tokenValid, pktStart} = p;
        @(negedge clk);
        {autoResume, sofValid, crc16Fail, pidValid, tokenValid, pktStart} = 6'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Reset values of twelve registers (not device address, on-the-go status or flags), plus an unmapped word that must read zero.
    task automatic chkReset;
        for (int i = 0; i < 12; i++) begin
            rd(rAddr[i], (i == 0) ? 32'h7 : (i == 2) ? 32'h2 : 32'h0);
        end
        rd(8'h44, 32'h0);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the few hundred cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'hcd91d0af));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chkReset();
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            wr(rAddr[i], r);
            rd(rAddr[i], r & rMask[i]);
        end
        wr(ADDR_RESET, $urandom);
        chkReset();
        $display("test registers done");
        wr(ADDR_FUNC, 32'h2);
        wr(ADDR_SERIAL, 32'h5);
        wr(ADDR_OTGCTL, 32'hd5);
        wr(ADDR_PHYCTL, 32'h40050);
        ob(2'h1, {8'hd5, 3'h5, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0, 4'b0101});
        otgCmd = 6'($urandom);
        serCmd = 3'h5;
        idle(6);
        rd(ADDR_OTGSTAT, {26'h0, otgCmd});
        rd(ADDR_SERIAL, 32'h55);
        $display("test controls done");
        wr(ADDR_DEVADDR, 32'h2a);
        lineCmd = LS_K;
        idle(8);
        ev(6'h01);
        rd(ADDR_FLAGS, 32'h10);
        tokenAddr = 7'h2a;
        tokenEp = 4'h5;
        pidValue = 4'h9;
        ev(6'h07);
        rd(ADDR_FLAGS, 32'h50);
        rd(ADDR_PID, 32'h9);
        rd(ADDR_EP, 32'h15);
        wr(ADDR_EPMARK, 32'h20);
        ev(6'h07);
        ob(2'h2, {4'h0, 5'h15, 4'h2});
        tokenAddr = 7'h2b;
        ev(6'h07);
        rd(ADDR_FLAGS, 32'h10);
        ev(6'h08);
        actCmd = 1'b1;
        errCmd = 1'b1;
        idle(6);
        rd(ADDR_FLAGS, 32'h17);
        wr(ADDR_MASKS, 32'h20014010);
        ob(2'h2, {4'b0101, 5'h15, 4'h2});
        wr(ADDR_STICKY, 32'h06);
        actCmd = 1'b0;
        errCmd = 1'b0;
        idle(6);
        ev(6'h01);
        rd(ADDR_FLAGS, 32'h16);
        wr(ADDR_FLAGS, 32'h06);
        rd(ADDR_FLAGS, 32'h10);
        sofValue = 11'h5a3;
        ev(6'h10);
        rd(ADDR_SOF, 32'h5a3);
        clkEn = 1'b0;
        wr(ADDR_SOF, 32'h123);
        rd(ADDR_SOF, 32'h5a3);
        clkEn = 1'b1;
        $display("test flags done");
        wr(ADDR_PHYCTL, 32'h0);
        ev(6'h20);
        rd(ADDR_PHYCTL, 32'h0);
        wr(ADDR_PHYCTL, 32'h80);
        ev(6'h20);
        rd(ADDR_PHYCTL, 32'h1080);
        lineCmd = LS_SE0;
        idle(8);
        ev(6'h20);
        rd(ADDR_PHYCTL, 32'h3080);
        wr(ADDR_PHYCTL, 32'h80);
        rd(ADDR_PHYCTL, 32'h80);
        wr(ADDR_PHYCTL, 32'h300);
        ev(6'h01);
        lineCmd = LS_J;
        idle(5);
        rd(ADDR_FLAGS, 32'h20);
        idle(12);
        rd(ADDR_FLAGS, 32'h28);
        $display("test wake and filter done");
        print_verdict();
    end
endmodule

// ### bench/usbfe_xcvr_model.sv
// Purpose: Stand-in for the transceiver that drives line state and status pins.
// Assumes: The bench commands pin levels between clock edges.
// Notes: Pins move just after a rising edge, so the sampler never sees a same-edge race.
`timescale 1ns/10ps
module usbfe_xcvr_model (
    // Clock.
    input wire logic clk,
    // Commanded levels from the bench.
    input wire logic [1:0] lineCmd,
    input wire logic [5:0] otgCmd,
    input wire logic [2:0] serCmd,
    input wire logic actCmd,
    input wire logic errCmd,
    // Transceiver pins.
    output logic [1:0] lineStatePin,
    output logic [5:0] otgStatusPin,
    output logic [2:0] rxSerialPin,
    output logic rxActivePin,
    output logic rxErrorPin
);
    // Launch every commanded level one edge later, as a real transceiver would lag.
    always @(posedge clk) begin
        lineStatePin <= lineCmd;
        otgStatusPin <= otgCmd;
        rxSerialPin <= serCmd;
        rxActivePin <= actCmd;
        rxErrorPin <= errCmd;
    end
endmodule

// ### hw/usbfe_control.sv
// Purpose: Register file and flag logic of the USB interface front end.
// Assumes: Packet decoder pulses arrive on clk; pins pass a 3-stage sampler.
// Notes: Registers are 32-bit words; unmapped offsets read zero.
// How it works
// - Function control holds a three-bit operating mode, reset 1, zero means normal.
// - Function bits 1 and 0 drive termination and transceiver select, reset 1.
// - On-the-go control bits drive VBUS and pull controls, all reset 0.
// - On-the-go status register shows the live transceiver session flags.
// - Serial control reads received line states at bits 6 to 4.
// - Serial bits 3, 2, 0 drive SE0, data and serial mode, reset 0.
// - Serial bit 1 is active-low transmit enable, reset 1.
// - Non-sticky flags clear when a packet starts; sticky ones wait for software.
// - Flag 6 sets on a valid token addressed to this device.
// - Flags 5, 4, 3 set on SE0, K and J line states.
// - Flag 2 sets on CRC16 failure; flags 1, 0 follow receive active, error.
// - Stickiness register holds flags until software writes one to clear.
// - Four 8-bit masks each OR selected flags onto one output port.
// - An 11-bit frame counter is readable, writable, reset to zero.
// - The last received packet identifier is captured, reset zero.
// - The last endpoint is captured in bits 3:0 with valid at bit 4.
// - Marked endpoints are delivered on the receive port ORed with 0x10.
// - Control bit 18 disables the pull-downs of the two wide ports.
// - Bits 13 and 12 record SE0 or K wake after auto resume; write 0 clears.
// - Line-state changes pass only after holding 2^N clock cycles.
// - Bit 7 lets hardware handle resume; else software polls filtered state.
// - Three control bits drive the transceiver configuration pins directly.
// - Any write to the reset register returns all state except the pin sampler to reset values.
// - Tokens match only the seven-bit device address register.
`timescale 1ns/10ps
module usbfe_control
    import usbfe_pkg::*;
#(
    parameter int FILT_W = 16
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // Register port, full 32-bit words.
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    // Transceiver status pins.
    input wire logic [1:0] lineStatePin,
    input wire logic [5:0] otgStatusPin,
    input wire logic [2:0] rxSerialPin,
    input wire logic rxActivePin,
    input wire logic rxErrorPin,
    // Packet decoder events on clk.
    input wire logic pktStart,
    input wire logic tokenValid,
    input wire logic [6:0] tokenAddr,
    input wire logic [3:0] tokenEp,
    input wire logic pidValid,
    input wire logic [3:0] pidValue,
    input wire logic crc16Fail,
    input wire logic sofValid,
    input wire logic [10:0] sofValue,
    input wire logic autoResume,
    // Transceiver controls.
    output logic [2:0] opMode,
    output logic termSelect,
    output logic xcvrSelect,
    output logic [7:0] otgControl,
    output logic txSe0,
    output logic txData,
    output logic txEnable_n,
    output logic fullLowSpeedSerial,
    output logic [2:0] transceiverConfigPins,
    output logic widePortPulldownDisable,
    output logic suspendAutoResume,
    output logic [3:0] filteredLineState,
    // Flag ports and receive endpoint.
    output logic flagPortA,
    output logic flagPortB,
    output logic flagPortC,
    output logic flagPortD,
    output logic [4:0] rxEndpoint
);
    import usbfe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage pin sampler; a change counts once stages two and three agree.
    // Line state rests at J, so leaving reset shows no false SE0 to the filter.
    localparam int SYNC_W = 13;
    localparam logic [SYNC_W-1:0] SYNC_RST = {LS_J, 11'h000};
    logic [SYNC_W-1:0] syncA, syncB, syncC, pinVal;
    logic [SYNC_W-1:0] pinIn;
    assign pinIn = {lineStatePin, otgStatusPin, rxSerialPin, rxActivePin, rxErrorPin};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= SYNC_RST;
            syncB <= SYNC_RST;
            syncC <= SYNC_RST;
            pinVal <= SYNC_RST;
        end else if (clkEn) begin
            syncA <= pinIn;
            syncB <= syncA;
            syncC <= syncB;
            if (syncB == syncC) begin
                pinVal <= syncC;
            end
        end
    end
    logic [1:0] lineRaw;
    logic [5:0] otgLive;
    logic [2:0] rxLive;
    assign lineRaw = pinVal[12:11];
    assign otgLive = pinVal[10:5];
    assign rxLive = pinVal[4:2];

    ////////////////////////////////////////////////////////////////////////////
    // Registers. The soft reset from a write to offset 0 acts like rst.
    logic wrEn, softRst;
    assign wrEn = clkEn && regWrite;
    assign softRst = wrEn && (regAddr == ADDR_RESET);
    logic [6:0] devAddr_reg;
    logic [4:0] func_reg;
    logic [7:0] otgCtl_reg;
    logic [3:0] serial_reg;
    logic [6:0] flags_reg, flags_next;
    logic [6:0] sticky_reg;
    logic [31:0] masks_reg;
    logic [10:0] sof_reg;
    logic [3:0] pid_reg;
    logic [4:0] ep_reg;
    logic [15:0] epMark_reg;
    logic [31:0] otgMask_reg;
    logic [8:0] power_reg;
    logic [18:0] phy_reg;

    // Plain software-written control registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            devAddr_reg <= '0;
            func_reg <= FUNC_RESET;
            otgCtl_reg <= '0;
            serial_reg <= SERIAL_RESET;
            sticky_reg <= '0;
            masks_reg <= '0;
            epMark_reg <= '0;
            otgMask_reg <= '0;
            power_reg <= '0;
        end else if (softRst) begin
            devAddr_reg <= '0;
            func_reg <= FUNC_RESET;
            otgCtl_reg <= '0;
            serial_reg <= SERIAL_RESET;
            sticky_reg <= '0;
            masks_reg <= '0;
            epMark_reg <= '0;
            otgMask_reg <= '0;
            power_reg <= '0;
        end else if (wrEn) begin
            unique case (regAddr)
                ADDR_DEVADDR: devAddr_reg <= regWdata[6:0];
                ADDR_FUNC: func_reg <= regWdata[4:0];
                ADDR_OTGCTL: otgCtl_reg <= regWdata[7:0] & 8'hdf;
                ADDR_SERIAL: serial_reg <= regWdata[3:0];
                ADDR_STICKY: sticky_reg <= regWdata[6:0];
                ADDR_MASKS: masks_reg <= regWdata;
                ADDR_EPMARK: epMark_reg <= regWdata[15:0];
                ADDR_OTGMASK: otgMask_reg <= regWdata;
                ADDR_POWER: power_reg <= regWdata[8:0];
                default: ;
            endcase
        end
    end

    // Outputs driven straight from the control registers.
    assign opMode = func_reg[4:2];
    assign termSelect = func_reg[1];
    assign xcvrSelect = func_reg[0];
    assign otgControl = otgCtl_reg;
    assign txSe0 = serial_reg[3];
    assign txData = serial_reg[2];
    assign txEnable_n = serial_reg[1];
    assign fullLowSpeedSerial = serial_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // Line-state filter: a new state must hold 2^N cycles before it passes.
    logic [1:0] lineFilt_reg, lineCand_reg;
    logic [FILT_W-1:0] filtCnt_reg;
    logic [FILT_W-1:0] filtTarget;
    assign filtTarget = FILT_W'(1) << phy_reg[11:8];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineFilt_reg <= LS_J;
            lineCand_reg <= LS_J;
            filtCnt_reg <= '0;
        end else if (softRst) begin
            lineFilt_reg <= LS_J;
            lineCand_reg <= LS_J;
            filtCnt_reg <= '0;
        end else if (clkEn) begin
            if (lineRaw != lineCand_reg) begin
                lineCand_reg <= lineRaw;
                filtCnt_reg <= FILT_W'(1);
            end else if (lineCand_reg != lineFilt_reg) begin
                if (filtCnt_reg >= filtTarget) begin
                    lineFilt_reg <= lineCand_reg;
                end else begin
                    filtCnt_reg <= filtCnt_reg + FILT_W'(1);
                end
            end
        end
    end
    assign filteredLineState = {2'h0, lineFilt_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Event flags. Set beats clear, both for the packet clear and software.
    logic [6:0] flagSet;
    logic tokenHit;
    assign tokenHit = tokenValid && (tokenAddr == devAddr_reg);
    always_comb begin
        flagSet = '0;
        flagSet[FLAG_TOKEN] = tokenHit;
        flagSet[FLAG_SE0] = (lineFilt_reg == LS_SE0);
        flagSet[FLAG_K] = (lineFilt_reg == LS_K);
        flagSet[FLAG_J] = (lineFilt_reg == LS_J);
        flagSet[FLAG_CRC] = crc16Fail;
    end
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_flag
            always_comb begin
                flags_next[gi] = flags_reg[gi];
                if (wrEn && regAddr == ADDR_FLAGS && regWdata[gi]) begin
                    flags_next[gi] = 1'b0;
                end else if (!sticky_reg[gi] && pktStart) begin
                    flags_next[gi] = 1'b0;
                end
                if (flagSet[gi]) begin
                    flags_next[gi] = 1'b1;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else if (softRst) begin
            flags_reg <= '0;
        end else if (clkEn) begin
            // Receive active and error track their inputs unless held sticky.
            flags_reg <= flags_next;
            if (!sticky_reg[FLAG_RXACT] || pinVal[1]) begin
                flags_reg[FLAG_RXACT] <= pinVal[1] | (sticky_reg[FLAG_RXACT] & flags_next[1]);
            end
            if (!sticky_reg[FLAG_RXERR] || pinVal[0]) begin
                flags_reg[FLAG_RXERR] <= pinVal[0] | (sticky_reg[FLAG_RXERR] & flags_next[0]);
            end
        end
    end

    // Mask ports follow the registered flags one cycle later; a soft reset clears them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flagPortA <= 1'b0;
            flagPortB <= 1'b0;
            flagPortC <= 1'b0;
            flagPortD <= 1'b0;
        end else if (clkEn) begin
            flagPortA <= !softRst && (|(masks_reg[6:0] & flags_reg));
            flagPortB <= !softRst && (|(masks_reg[14:8] & flags_reg));
            flagPortC <= !softRst && (|(masks_reg[22:16] & flags_reg));
            flagPortD <= !softRst && (|(masks_reg[30:24] & flags_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame counter, packet identifier and endpoint capture.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sof_reg <= '0;
            pid_reg <= '0;
            ep_reg <= '0;
            rxEndpoint <= '0;
        end else if (softRst) begin
            sof_reg <= '0;
            pid_reg <= '0;
            ep_reg <= '0;
            rxEndpoint <= '0;
        end else if (clkEn) begin
            // A software write loses to a frame arriving in the same cycle.
            if (sofValid) begin
                sof_reg <= sofValue;
            end else if (wrEn && regAddr == ADDR_SOF) begin
                sof_reg <= regWdata[10:0];
            end
            if (pidValid) begin
                pid_reg <= pidValue;
            end
            if (tokenHit) begin
                ep_reg <= {1'b1, tokenEp};
                rxEndpoint <= epMark_reg[tokenEp] ? ({1'b0, tokenEp} | EP_MARK_OR)
                                                  : {1'b0, tokenEp};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transceiver control word with wake-reason bits.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phy_reg <= '0;
        end else if (softRst) begin
            phy_reg <= '0;
        end else if (clkEn) begin
            if (wrEn && regAddr == ADDR_PHYCTL) begin
                phy_reg[PHY_PDDIS] <= regWdata[PHY_PDDIS];
                phy_reg[11:4] <= regWdata[11:4];
                if (!regWdata[PHY_WAKE_SE0]) begin
                    phy_reg[PHY_WAKE_SE0] <= 1'b0;
                end
                if (!regWdata[PHY_WAKE_K]) begin
                    phy_reg[PHY_WAKE_K] <= 1'b0;
                end
            end
            // Hardware set wins over a clear written in the same cycle.
            if (autoResume && phy_reg[PHY_AUTORES] && lineFilt_reg == LS_SE0) begin
                phy_reg[PHY_WAKE_SE0] <= 1'b1;
            end
            if (autoResume && phy_reg[PHY_AUTORES] && lineFilt_reg == LS_K) begin
                phy_reg[PHY_WAKE_K] <= 1'b1;
            end
        end
    end
    assign widePortPulldownDisable = phy_reg[PHY_PDDIS];
    assign suspendAutoResume = phy_reg[PHY_AUTORES];
    assign transceiverConfigPins = phy_reg[6:4];

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits and unmapped offsets read zero.
    always_comb begin
        regRdata = '0;
        if (regRead) begin
            unique case (regAddr)
                ADDR_DEVADDR: regRdata[6:0] = devAddr_reg;
                ADDR_FUNC: regRdata[4:0] = func_reg;
                ADDR_OTGCTL: regRdata[7:0] = otgCtl_reg;
                ADDR_OTGSTAT: regRdata[5:0] = otgLive;
                ADDR_SERIAL: regRdata[6:0] = {rxLive, serial_reg};
                ADDR_FLAGS: regRdata[6:0] = flags_reg;
                ADDR_STICKY: regRdata[6:0] = sticky_reg;
                ADDR_MASKS: regRdata = masks_reg;
                ADDR_SOF: regRdata[10:0] = sof_reg;
                ADDR_PID: regRdata[3:0] = pid_reg;
                ADDR_EP: regRdata[4:0] = ep_reg;
                ADDR_EPMARK: regRdata[15:0] = epMark_reg;
                ADDR_OTGMASK: regRdata = otgMask_reg;
                ADDR_POWER: regRdata[8:0] = power_reg;
                ADDR_PHYCTL: regRdata[18:0] = phy_reg & 19'h43ff0;
                default: regRdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_func_reset;
        @(posedge clk) disable iff (rst)
        $past(softRst) |-> (opMode == 3'h1 && termSelect && xcvrSelect);
    endproperty
    a_func_reset: assert property (p_func_reset) else $error("soft reset value wrong");

    property p_txen;
        @(posedge clk) disable iff (rst)
        (wrEn && regAddr == ADDR_SERIAL && !softRst) |=> (txEnable_n == $past(regWdata[1]));
    endproperty
    a_txen: assert property (p_txen) else $error("tx enable not written");

    property p_token;
        @(posedge clk) disable iff (rst || softRst)
        (clkEn && tokenHit) |=> flags_reg[FLAG_TOKEN];
    endproperty
    a_token: assert property (p_token) else $error("token flag not set");

    property p_sticky;
        @(posedge clk) disable iff (rst)
        (clkEn && sticky_reg[FLAG_CRC] && flags_reg[FLAG_CRC] && !wrEn)
            |=> flags_reg[FLAG_CRC];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag lost");

    property p_nonsticky;
        @(posedge clk) disable iff (rst)
        (clkEn && pktStart && !sticky_reg[FLAG_CRC] && !crc16Fail) |=> !flags_reg[FLAG_CRC];
    endproperty
    a_nonsticky: assert property (p_nonsticky) else $error("flag not cleared");

    property p_port;
        @(posedge clk) disable iff (rst)
        (clkEn && !softRst) |=> (flagPortA == |($past(masks_reg[6:0]) & $past(flags_reg)));
    endproperty
    a_port: assert property (p_port) else $error("port a mismatch");

    property p_epmark;
        @(posedge clk) disable iff (rst || softRst)
        (clkEn && tokenHit && epMark_reg[tokenEp]) |=> rxEndpoint[4];
    endproperty
    a_epmark: assert property (p_epmark) else $error("mark not applied");

    property p_conf;
        @(posedge clk) disable iff (rst)
        (wrEn && regAddr == ADDR_PHYCTL && !softRst)
            |=> (transceiverConfigPins == $past(regWdata[6:4])
            && widePortPulldownDisable == $past(regWdata[PHY_PDDIS]));
    endproperty
    a_conf: assert property (p_conf) else $error("config pins wrong");

    c_token: cover property (@(posedge clk) disable iff (rst) clkEn && tokenHit);
    c_wake: cover property (@(posedge clk) disable iff (rst) phy_reg[PHY_WAKE_K]);
    c_filt: cover property (@(posedge clk) disable iff (rst) $changed(lineFilt_reg));
endmodule

// ### hw/usbfe_pkg.sv
// Purpose: Constants for the USB interface front-end control block.
// Assumes: Registers are 32-bit words at word-aligned printed offsets.
// Notes: Offsets are byte addresses on the peripheral register port.
package usbfe_pkg;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] ADDR_DEVADDR = 8'h08;
    localparam logic [7:0] ADDR_FUNC = 8'h0c;
    localparam logic [7:0] ADDR_OTGCTL = 8'h10;
    localparam logic [7:0] ADDR_OTGSTAT = 8'h14;
    localparam logic [7:0] ADDR_SERIAL = 8'h18;
    localparam logic [7:0] ADDR_FLAGS = 8'h1c;
    localparam logic [7:0] ADDR_STICKY = 8'h20;
    localparam logic [7:0] ADDR_MASKS = 8'h24;
    localparam logic [7:0] ADDR_SOF = 8'h28;
    localparam logic [7:0] ADDR_PID = 8'h2c;
    localparam logic [7:0] ADDR_EP = 8'h30;
    localparam logic [7:0] ADDR_EPMARK = 8'h34;
    localparam logic [7:0] ADDR_OTGMASK = 8'h38;
    localparam logic [7:0] ADDR_POWER = 8'h3c;
    localparam logic [7:0] ADDR_PHYCTL = 8'h40;
    localparam logic [4:0] FUNC_RESET = 5'h07;
    localparam logic [3:0] SERIAL_RESET = 4'h2;
    localparam int FLAG_TOKEN = 6;
    localparam int FLAG_SE0 = 5;
    localparam int FLAG_K = 4;
    localparam int FLAG_J = 3;
    localparam int FLAG_CRC = 2;
    localparam int FLAG_RXACT = 1;
    localparam int FLAG_RXERR = 0;
    localparam int PHY_PDDIS = 18;
    localparam int PHY_WAKE_SE0 = 13;
    localparam int PHY_WAKE_K = 12;
    localparam int PHY_FILT_LO = 8;
    localparam int PHY_AUTORES = 7;
    localparam int PHY_CONF_LO = 4;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam logic [4:0] EP_MARK_OR = 5'h10;
endpackage
